// file: verilog/lrc_cfg.svh
`ifndef LRC_CFG_SVH
`define LRC_CFG_SVH
// register pointers
`define LRC_PTR_RESULT 8'h00
`define LRC_PTR_CTRL 8'h01
// reset values
`define LRC_CTRL_RST 16'hc810
`define LRC_RESULT_RST 16'h0000
// read-only control bits 8..5
`define LRC_CTRL_RO_MASK 16'h01e0
// control field positions
`define LRC_RN_HI 15
`define LRC_RN_LO 12
`define LRC_CT_BIT 11
`define LRC_MODE_HI 10
`define LRC_MODE_LO 9
`define LRC_OVF_BIT 8
`define LRC_CRF_BIT 7
`define LRC_ME_BIT 2
// field codes
`define LRC_RN_AUTO 4'hc
`define LRC_EXP_ZERO 4'h0
`define LRC_MODE_OFF 2'b00
`define LRC_MODE_SINGLE 2'b01
// bus codes
`define LRC_GC_ADDR 8'h00
`define LRC_GC_RESET 8'h06
`define LRC_LAST_BIT 3'h7
`endif

// file: verilog/lrc_pkg.sv
`default_nettype none
package lrc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_DEC = 3'b010,
      ST_ACK = 3'b011,
      ST_TX = 3'b100,
      ST_RACK = 3'b101
   } lrc_bus_state_t;

   // one finished conversion from the light front end
   typedef struct packed {
      logic [3:0] rangeUsed;
      logic [11:0] count;
      logic overflow;
   } lrc_conv_result_t;

   // settings handed to the light front end
   typedef struct packed {
      logic [3:0] rangeSel;
      logic autoRange;
      logic longConv;
   } lrc_conv_cfg_t;
endpackage
`default_nettype wire

// file: verilog/lrc_light_result.sv
// Notes on behaviour
// - read-only 16-bit word, exponent plus mantissa
// - exponent sits in bits 15..12
// - mantissa unsigned binary in bits 11..0
// - codes 0..11 weigh 0.01 times two^code
// - word holds latest completed conversion
// - mask on, manual range: exponent reads zero
// - control write aborts running conversion
// - control write restarts if settings ask
// - range select bits 15..12, exponent coding
// - range code 1100b means automatic ranging
// - auto ranging reports chosen range as exponent
// - range select powers up as 1100b
// - control register resets to c810h
// - control bits 8..5 read-only, rest writable
// - registers over two-wire bus, MSB first
// - pointer kept until rewritten
// - general call 06h acks and resets all
`timescale 1ns/1ps
`default_nettype none
`include "lrc_cfg.svh"
module lrc_light_result
   import lrc_pkg::*;
#(
   parameter int MANT_W = 12,
   parameter int EXP_W = 4
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [6:0] devAddr,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic convDone,
   input wire lrc_conv_result_t convResult,
   output logic convStart,
   output logic convAbort,
   output lrc_conv_cfg_t convCfg
);
   if (MANT_W != 12 || EXP_W != 4) begin : g_chk
      $error("result word must split 4 + 12 bits");
   end
   function automatic logic [15:0] regRead(input logic [7:0] ptr,
         input logic [15:0] res, input logic [15:0] ctl);
      case (ptr)
         `LRC_PTR_RESULT: return res;
         `LRC_PTR_CTRL: return ctl;
         default: return 16'h0000;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////
   lrc_bus_state_t stateReg;
   logic sclPrevReg, sdaPrevReg;
   logic [2:0] bitCntReg;
   logic [1:0] byteIdxReg;
   logic [7:0] shiftReg, ptrReg, hiByteReg;
   logic [15:0] txReg, wrDataReg, ctrlReg, ctrlNext, resultReg, rdWord;
   logic isReadReg, gcModeReg, txHalfReg, ackdReg, sdaOeReg, sdaOutReg;
   logic wrStrobeReg, gcStrobeReg, ctrlRdReg;
   logic busyReg, convStartReg, convAbortReg;
   lrc_conv_cfg_t cfgReg;
   logic sclRise, sclFall, startCond, stopCond, ctrlWr, doneOk;
   logic [3:0] rangeSel, expOut;
   assign sdaOut = sdaOutReg;
   assign sdaOe = sdaOeReg;
   assign convStart = convStartReg;
   assign convAbort = convAbortReg;
   assign convCfg = cfgReg;
   assign sclRise = sclIn & ~sclPrevReg;
   assign sclFall = ~sclIn & sclPrevReg;
   assign startCond = sclIn & sclPrevReg & sdaPrevReg & ~sdaIn;
   assign stopCond = sclIn & sclPrevReg & ~sdaPrevReg & sdaIn;
   assign rdWord = regRead(ptrReg, resultReg, ctrlReg);
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sclPrevReg <= 1'b1;
         sdaPrevReg <= 1'b1;
         sdaOutReg <= 1'b0;
      end else begin
         sclPrevReg <= sclIn;
         sdaPrevReg <= sdaIn;
         sdaOutReg <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////
   // two-wire slave; sda only ever pulled low, changed on scl fall
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         stateReg <= ST_IDLE;
         bitCntReg <= 3'h0;
         byteIdxReg <= 2'h0;
         shiftReg <= 8'h00;
         ptrReg <= `LRC_PTR_RESULT;
         hiByteReg <= 8'h00;
         txReg <= 16'h0000;
         wrDataReg <= 16'h0000;
         isReadReg <= 1'b0;
         gcModeReg <= 1'b0;
         txHalfReg <= 1'b0;
         ackdReg <= 1'b0;
         sdaOeReg <= 1'b0;
         wrStrobeReg <= 1'b0;
         gcStrobeReg <= 1'b0;
         ctrlRdReg <= 1'b0;
      end else begin
         wrStrobeReg <= 1'b0;
         gcStrobeReg <= 1'b0;
         ctrlRdReg <= 1'b0;
         if (startCond) begin
            stateReg <= ST_RX;
            bitCntReg <= 3'h0;
            byteIdxReg <= 2'h0;
            gcModeReg <= 1'b0;
            sdaOeReg <= 1'b0;
         end else if (stopCond) begin
            stateReg <= ST_IDLE;
            sdaOeReg <= 1'b0;
         end else begin
            case (stateReg)
               ST_RX: if (sclRise) begin
                  shiftReg <= {shiftReg[6:0], sdaIn};
                  bitCntReg <= bitCntReg + 3'h1;
                  if (bitCntReg == `LRC_LAST_BIT) stateReg <= ST_DEC;
               end
               ST_DEC: if (sclFall) begin
                  stateReg <= ST_ACK;
                  sdaOeReg <= 1'b1;
                  // data bytes past the pair wrap to a fresh msb
                  byteIdxReg <= (byteIdxReg == 2'h3) ? 2'h2 : byteIdxReg + 2'h1;
                  case (byteIdxReg)
                     2'h0: begin
                        if (shiftReg[7:1] == devAddr) begin
                           isReadReg <= shiftReg[0];
                           txReg <= rdWord;
                           txHalfReg <= 1'b0;
                           ctrlRdReg <= shiftReg[0] && ptrReg == `LRC_PTR_CTRL;
                        end else if (shiftReg == `LRC_GC_ADDR) begin
                           gcModeReg <= 1'b1;
                           isReadReg <= 1'b0;
                        end else begin
                           stateReg <= ST_IDLE;
                           sdaOeReg <= 1'b0;
                        end
                     end
                     2'h1: begin
                        if (!gcModeReg) begin
                           ptrReg <= shiftReg;
                        end else if (shiftReg == `LRC_GC_RESET) begin
                           gcStrobeReg <= 1'b1;
                           ptrReg <= `LRC_PTR_RESULT;
                        end else begin
                           stateReg <= ST_IDLE;
                           sdaOeReg <= 1'b0;
                        end
                     end
                     default: begin
                        if (gcModeReg) begin
                           stateReg <= ST_IDLE;
                           sdaOeReg <= 1'b0;
                        end else if (byteIdxReg == 2'h2) begin
                           hiByteReg <= shiftReg;
                        end else begin
                           wrStrobeReg <= 1'b1;
                           wrDataReg <= {hiByteReg, shiftReg};
                        end
                     end
                  endcase
               end
               ST_ACK: if (sclFall) begin
                  bitCntReg <= 3'h0;
                  if (isReadReg) begin
                     stateReg <= ST_TX;
                     sdaOeReg <= ~txReg[15];
                  end else begin
                     stateReg <= ST_RX;
                     sdaOeReg <= 1'b0;
                  end
               end
               ST_TX: if (sclFall) begin
                  bitCntReg <= bitCntReg + 3'h1;
                  txReg <= {txReg[14:0], 1'b0};
                  if (bitCntReg == `LRC_LAST_BIT) begin
                     stateReg <= ST_RACK;
                     sdaOeReg <= 1'b0;
                  end else begin
                     sdaOeReg <= ~txReg[14];
                  end
               end
               ST_RACK: begin
                  if (sclRise) begin
                     ackdReg <= ~sdaIn;
                  end else if (sclFall) begin
                     if (ackdReg) begin
                        stateReg <= ST_TX;
                        bitCntReg <= 3'h0;
                        txHalfReg <= ~txHalfReg;
                        // after the lsb the same register is sent again
                        if (txHalfReg) begin
                           txReg <= rdWord;
                           sdaOeReg <= ~rdWord[15];
                        end else begin
                           sdaOeReg <= ~txReg[15];
                        end
                     end else begin
                        stateReg <= ST_IDLE;
                     end
                  end
               end
               default: stateReg <= ST_IDLE;
            endcase
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   assign ctrlWr = wrStrobeReg && ptrReg == `LRC_PTR_CTRL;
   // abort wins over a result landing in the same cycle
   assign doneOk = convDone && busyReg && !ctrlWr && !gcStrobeReg;
   assign rangeSel = ctrlReg[`LRC_RN_HI:`LRC_RN_LO];
   // exponent is the range code, lsb weight 0.01 lux times 2^code
   assign expOut = (ctrlReg[`LRC_ME_BIT] && rangeSel < `LRC_RN_AUTO) ?
      `LRC_EXP_ZERO : convResult.rangeUsed;
   always_comb begin
      ctrlNext = ctrlReg;
      if (ctrlRdReg) ctrlNext[`LRC_CRF_BIT] = 1'b0;
      if (ctrlWr) begin
         ctrlNext = (wrDataReg & ~`LRC_CTRL_RO_MASK) |
            (ctrlNext & `LRC_CTRL_RO_MASK);
      end
      if (doneOk) begin
         // set after the read clear so a fresh result is never missed
         ctrlNext[`LRC_CRF_BIT] = 1'b1;
         ctrlNext[`LRC_OVF_BIT] = convResult.overflow;
         if (ctrlReg[`LRC_MODE_HI:`LRC_MODE_LO] == `LRC_MODE_SINGLE) begin
            ctrlNext[`LRC_MODE_HI:`LRC_MODE_LO] = `LRC_MODE_OFF;
         end
      end
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrlReg <= `LRC_CTRL_RST;
         resultReg <= `LRC_RESULT_RST;
      end else if (gcStrobeReg) begin
         ctrlReg <= `LRC_CTRL_RST;
         resultReg <= `LRC_RESULT_RST;
      end else begin
         ctrlReg <= ctrlNext;
         // host writes never reach the result word
         if (doneOk) resultReg <= {expOut, convResult.count};
      end
   end
   ////////////////////////////////////////////////////////////////
   // conversion sequencing toward the light front end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         busyReg <= 1'b0;
         convStartReg <= 1'b0;
         convAbortReg <= 1'b0;
         cfgReg <= '0;
      end else begin
         convStartReg <= 1'b0;
         convAbortReg <= 1'b0;
         cfgReg.rangeSel <= ctrlNext[`LRC_RN_HI:`LRC_RN_LO];
         cfgReg.autoRange <= ctrlNext[`LRC_RN_HI:`LRC_RN_LO] == `LRC_RN_AUTO;
         cfgReg.longConv <= ctrlNext[`LRC_CT_BIT];
         if (gcStrobeReg) begin
            convAbortReg <= busyReg;
            busyReg <= 1'b0;
         end else if (ctrlWr) begin
            convAbortReg <= busyReg;
            if (wrDataReg[`LRC_MODE_HI:`LRC_MODE_LO] != `LRC_MODE_OFF) begin
               convStartReg <= 1'b1;
               busyReg <= 1'b1;
            end else begin
               busyReg <= 1'b0;
            end
         end else if (doneOk) begin
            if (ctrlReg[`LRC_MODE_HI]) convStartReg <= 1'b1;
            else busyReg <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence s_ctrl_wr;
      wrStrobeReg && ptrReg == `LRC_PTR_CTRL;
   endsequence
   sequence s_done;
      convDone && busyReg && !ctrlWr && !gcStrobeReg;
   endsequence
   property p_gc_reset;
      gcStrobeReg |=> ctrlReg == `LRC_CTRL_RST && resultReg == `LRC_RESULT_RST;
   endproperty
   a_gc_reset: assert property (p_gc_reset) else $error("general call reset missed");
   property p_abort;
      s_ctrl_wr and busyReg |=> convAbort ##1 !convAbort;
   endproperty
   a_abort: assert property (p_abort) else $error("abort not pulsed");
   property p_restart;
      s_ctrl_wr and wrDataReg[`LRC_MODE_HI:`LRC_MODE_LO] != `LRC_MODE_OFF
         |=> convStart && busyReg;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart after write");
   property p_mask;
      s_done and ctrlReg[`LRC_ME_BIT] && rangeSel < `LRC_RN_AUTO
         |=> resultReg[15:12] == `LRC_EXP_ZERO;
   endproperty
   a_mask: assert property (p_mask) else $error("exponent not masked");
   property p_auto_exp;
      s_done and rangeSel == `LRC_RN_AUTO
         |=> resultReg[15:12] == $past(convResult.rangeUsed);
   endproperty
   a_auto_exp: assert property (p_auto_exp) else $error("auto range not reported");
   property p_mantissa;
      s_done |=> resultReg[11:0] == $past(convResult.count);
   endproperty
   a_mantissa: assert property (p_mantissa) else $error("mantissa not latest");
   property p_result_ro;
      !convDone && !gcStrobeReg |=> $stable(resultReg);
   endproperty
   a_result_ro: assert property (p_result_ro) else $error("result changed");
   property p_flags_ro;
      s_ctrl_wr and !convDone and !ctrlRdReg
         |=> ctrlReg[8:5] == $past(ctrlReg[8:5]);
   endproperty
   a_flags_ro: assert property (p_flags_ro) else $error("flag bits written");
   property p_ptr_hold;
      stateReg != ST_DEC |=> $stable(ptrReg);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointer lost");
   property p_auto_cfg;
      rangeSel == `LRC_RN_AUTO && !ctrlWr && !gcStrobeReg |=> convCfg.autoRange;
   endproperty
   a_auto_cfg: assert property (p_auto_cfg) else $error("auto range not set");
endmodule
`default_nettype wire

// file: tb/lrc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lrc_host_model (
   input wire logic core_clk,
   input wire logic sdaOe,
   output logic sclIn,
   output logic sdaIn
);
   logic hostSda;
   // pull-up wire: low if either party pulls
   assign sdaIn = hostSda & ~sdaOe;
   initial begin
      sclIn = 1'b1;
      hostSda = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic start;
      wt(1);
      hostSda = 1'b1;
      wt(3);
      sclIn = 1'b1;
      wt(4);
      hostSda = 1'b0;
      wt(4);
      sclIn = 1'b0;
   endtask
   task automatic stop;
      wt(1);
      hostSda = 1'b0;
      wt(3);
      sclIn = 1'b1;
      wt(4);
      hostSda = 1'b1;
      wt(4);
   endtask
   // data only moves a cycle after scl fell, never while scl is high
   task automatic bitx(input logic b, output logic r);
      wt(1);
      hostSda = b;
      wt(3);
      sclIn = 1'b1;
      wt(4);
      r = sdaIn;
      sclIn = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, ack);
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, r);
         d[i] = r;
      end
      bitx(last, r);
   endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import lrc_pkg::*;
   localparam logic [6:0] ADDR = 7'h44;
   logic core_clk, rstn, convDone, sclIn, sdaIn, sdaOut, sdaOe, convStart, convAbort;
   lrc_conv_result_t convResult;
   lrc_conv_cfg_t convCfg;
   int n_mismatch = 0, n_tests = 0, nStart = 0, nAbort = 0;
   logic [31:0] seed = 32'd83933;
   lrc_light_result dut_u (.core_clk(core_clk), .rstn(rstn), .devAddr(ADDR), .sclIn(sclIn),
      .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .convDone(convDone),
      .convResult(convResult), .convStart(convStart), .convAbort(convAbort), .convCfg(convCfg));
   lrc_host_model hm (.core_clk(core_clk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (convStart === 1'b1) nStart++;
      if (convAbort === 1'b1) nAbort++;
   end
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] expRes(input logic [3:0] rn, input logic me,
         input logic [3:0] used, input logic [11:0] cnt);
      return {(me && rn < 4'hc) ? 4'h0 : used, cnt};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [15:0] d, input bit withData);
      logic [3:0] ak;
      ak = 4'h0;
      hm.start;
      hm.wbyte({ADDR, 1'b0}, ak[0]);
      hm.wbyte(ptr, ak[1]);
      if (withData) begin
         hm.wbyte(d[15:8], ak[2]);
         hm.wbyte(d[7:0], ak[3]);
      end
      hm.stop;
      chk({12'h000, ak}, 16'h0000);
   endtask
   task automatic rd(input logic [7:0] ptr, input bit setPtr, output logic [15:0] d);
      logic a;
      if (setPtr) wr(ptr, 16'h0000, 1'b0);
      hm.start;
      hm.wbyte({ADDR, 1'b1}, a);
      hm.rbyte(1'b0, d[15:8]);
      hm.rbyte(1'b1, d[7:0]);
      hm.stop;
      chk({15'h0000, a}, 16'h0000);
   endtask
   task automatic conv(input logic [3:0] rng, input logic [11:0] cnt, input logic ovf);
      @(negedge core_clk);
      convResult = {rng, cnt, ovf};
      convDone = 1'b1;
      @(negedge core_clk);
      convDone = 1'b0;
      repeat (3) @(negedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] v;
      logic a, b, me;
      logic [31:0] r;
      logic [3:0] rn, used;
      logic [11:0] cnt;
      int s0;
      rstn = 1'b0;
      convDone = 1'b0;
      convResult = '0;
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      rstn = 1'b1;
      repeat (3) @(negedge core_clk);
      chk({10'h000, convCfg}, {10'h000, 4'hc, 1'b1, 1'b1});
      rd(8'h01, 1'b1, v);
      chk(v, 16'hc810);
      rd(8'h00, 1'b1, v);
      chk(v, 16'h0000);
      hm.start;
      hm.wbyte({ADDR ^ 7'h01, 1'b0}, a);
      hm.stop;
      chk({15'h0000, a}, 16'h0001);
      // flag bits written high must not stick; mode stays off
      wr(8'h01, 16'h41e4, 1'b1);
      rd(8'h01, 1'b1, v);
      chk(v, 16'h4004);
      rd(8'h01, 1'b0, v);
      chk(v, 16'h4004);
      chk({12'h000, convCfg.rangeSel}, 16'h0004);
      wr(8'h00, 16'hffff, 1'b1);
      rd(8'h00, 1'b1, v);
      chk(v, 16'h0000);
      // codes 0..11 manual, 12 automatic; reserved codes are never written
      for (int e = 0; e <= 12; e++) begin
         r = rnd();
         rn = e[3:0];
         me = r[0];
         cnt = r[12:1];
         used = (e == 12) ? 4'(r[31:16] % 16'd12) : rn;
         s0 = nStart;
         wr(8'h01, {rn, 1'b0, 2'b01, 4'h0, 2'b00, me, 2'b00}, 1'b1);
         chk(16'(nStart - s0), 16'h0001);
         chk({15'h0000, convCfg.autoRange}, {15'h0000, rn == 4'hc});
         conv(used, cnt, r[13]);
         rd(8'h00, 1'b1, v);
         chk(v, expRes(rn, me, used, cnt));
      end
      // single shot has fallen back to off; flags show the last result
      rd(8'h01, 1'b1, v);
      chk(v, {4'hc, 3'b000, r[13], 1'b1, 4'h0, me, 2'b00});
      // the read above cleared conversion-ready
      rd(8'h01, 1'b0, v);
      chk(v, {4'hc, 3'b000, r[13], 1'b0, 4'h0, me, 2'b00});
      s0 = nAbort;
      wr(8'h01, 16'h3200, 1'b1);
      wr(8'h01, 16'h3200, 1'b1);
      chk(16'(nAbort - s0), 16'h0001);
      hm.start;
      hm.wbyte(8'h00, a);
      hm.wbyte(8'h06, b);
      hm.stop;
      chk({14'h0000, a, b}, 16'h0000);
      rd(8'h00, 1'b0, v);
      chk(v, 16'h0000);
      rd(8'h01, 1'b1, v);
      chk(v, 16'hc810);
      chk({15'h0000, sdaOut}, 16'h0000);
      results;
   end
   initial begin
      #(100 * 80000);
      n_mismatch++;
      results;
   end
endmodule
`default_nettype wire
